// ==== common/exception_vector_pkg.sv ====
// constants for the exception vector prioritizer: register map, vector offsets,
// reset vectors and field positions
// assumes a 32-bit classic wishbone register bus and 16-bit cpu vectors
package exception_vector_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_BASE_PAGE = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;

   // ----------------------------------------------------------------
   // base page field and reset values
   // ----------------------------------------------------------------
   localparam int BASE_FIELD_LSB = 0;
   localparam int BASE_FIELD_W = 8;
   localparam logic [7:0] BASE_PAGE_RESET = 8'hFF;
   localparam logic [7:0] DEBUG_PAGE = 8'hFF;
   localparam logic [7:0] VECTOR_LOW_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // status register fields
   // ----------------------------------------------------------------
   localparam int STAT_VECTOR_LSB = 0;
   localparam int STAT_WAKE_BIT = 16;
   localparam int STAT_DEBUG_BIT = 17;
   localparam int STAT_PENDING_BIT = 18;
   localparam int STAT_RESET_BIT = 19;

   // ----------------------------------------------------------------
   // vector offsets from the base
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_SPURIOUS = 8'h80;
   localparam logic [7:0] OFF_GEN_FIRST = 8'h82;
   localparam logic [7:0] OFF_GEN_LAST = 8'hF0;
   localparam logic [7:0] OFF_EXT_PIN = 8'hF2;
   localparam logic [7:0] OFF_PRIO_PIN = 8'hF4;
   localparam logic [7:0] OFF_SOFTWARE = 8'hF6;
   localparam logic [7:0] OFF_TRAP = 8'hF8;
   localparam int GEN_COUNT = 56;

   // ----------------------------------------------------------------
   // fixed reset vectors
   // ----------------------------------------------------------------
   localparam logic [15:0] VEC_RST_PIN = 16'hFFFE;
   localparam logic [15:0] VEC_RST_CLOCK = 16'hFFFC;
   localparam logic [15:0] VEC_RST_WATCHDOG = 16'hFFFA;

endpackage

// ==== rtl/exception_vector_prioritizer.sv ====
// exception vector prioritizer: picks the highest pending exception and
// returns its 16-bit vector while the cpu holds its vector request strobe
// assumes requests are synchronous to sys_clk and held until serviced;
// wake outputs are combinational so they still work with the clock gated
`timescale 1ns/1ps

module exception_vector_prioritizer #(
   parameter int GEN_N = exception_vector_pkg::GEN_COUNT
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [exception_vector_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // reset sources
   input wire logic rst_pin_req,
   input wire logic rst_clock_req,
   input wire logic rst_watchdog_req,
   // non-maskable sources
   input wire logic trap_req,
   input wire logic software_interrupt,
   // maskable sources
   input wire logic priority_pin_request,
   input wire logic ext_pin_req,
   input wire logic ext_pin_enable,
   input wire logic [GEN_N-1:0] gen_req,
   input wire logic [GEN_N-1:0] gen_enable,
   // cpu condition flags and mode
   input wire logic cpu_i_mask,
   input wire logic cpu_x_mask,
   input wire logic debug_active,
   // vector handshake
   input wire logic vector_req,
   output logic [15:0] vector_out,
   output logic vector_valid,
   // wake-up
   output logic wake_req,
   output logic wake_no_service
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // index of the highest set bit, with a found flag in bit 8
   function automatic logic [8:0] top_index(input logic [GEN_N-1:0] v);
      logic [8:0] r;
      r = 9'h000;
      for (int i = 0; i < GEN_N; i++) begin
         if (v[i]) begin
            r = {1'b1, 8'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] make_vector(input logic [7:0] page, input logic [7:0] off);
      return {page, off};
   endfunction

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [7:0] vector_base_page_q;
   logic [7:0] vector_base_page_d;
   logic wb_ack_q;
   logic [31:0] wb_dat_q;
   logic [31:0] wb_dat_d;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
   wire hit_base = wb_adr_i == exception_vector_pkg::REG_BASE_PAGE;
   wire hit_status = wb_adr_i == exception_vector_pkg::REG_STATUS;
   wire base_write = bus_req & wb_we_i & hit_base & wb_sel_i[0];

   // ----------------------------------------------------------------
   // request qualification
   // ----------------------------------------------------------------
   wire any_reset = rst_pin_req | rst_clock_req | rst_watchdog_req;
   // priority pin taken when its mask is clear
   wire prio_taken = priority_pin_request & ~cpu_x_mask;
   // general gating by higher non-i-maskable requests
   wire high_pending = software_interrupt | trap_req | priority_pin_request;
   wire gen_allow = ~cpu_i_mask & ~high_pending;
   wire ext_taken = ext_pin_req & ext_pin_enable & gen_allow;
   wire [GEN_N-1:0] gen_live = gen_req & gen_enable;
   wire [GEN_N-1:0] gen_taken = gen_allow ? gen_live : '0;
   wire [8:0] gen_top = top_index(gen_taken);
   wire gen_found = gen_top[8];

   // debug forces page to all ones
   wire [7:0] page = debug_active ? exception_vector_pkg::DEBUG_PAGE : vector_base_page_q;

   // general vector from the winning index
   wire [7:0] gen_off = 8'(exception_vector_pkg::OFF_GEN_FIRST + {gen_top[6:0], 1'b0});

   // ----------------------------------------------------------------
   // priority selection
   // ----------------------------------------------------------------
   logic [15:0] sel_vector;
   always_comb begin
      if (rst_pin_req) begin
         sel_vector = exception_vector_pkg::VEC_RST_PIN;
      end else if (rst_clock_req) begin
         sel_vector = exception_vector_pkg::VEC_RST_CLOCK;
      end else if (rst_watchdog_req) begin
         sel_vector = exception_vector_pkg::VEC_RST_WATCHDOG;
      end else if (trap_req) begin
         sel_vector = make_vector(page, exception_vector_pkg::OFF_TRAP);
      end else if (software_interrupt) begin
         sel_vector = make_vector(page, exception_vector_pkg::OFF_SOFTWARE);
      end else if (prio_taken) begin
         sel_vector = make_vector(page, exception_vector_pkg::OFF_PRIO_PIN);
      end else if (ext_taken) begin
         sel_vector = make_vector(page, exception_vector_pkg::OFF_EXT_PIN);
      end else if (gen_found) begin
         sel_vector = make_vector(page, gen_off);
      end else begin
         sel_vector = make_vector(page, exception_vector_pkg::OFF_SPURIOUS);
      end
   end

   // combinational so the vector is valid in the strobe cycle
   assign vector_out = vector_req ? sel_vector : 16'h0000;
   assign vector_valid = vector_req;

   // ----------------------------------------------------------------
   // wake-up path
   // ----------------------------------------------------------------
   // no clock in this path, so it works while gated
   // general sources wake only with mask clear
   // priority pin wakes regardless of its mask
   wire gen_wake = ~cpu_i_mask & ((ext_pin_req & ext_pin_enable) | (|gen_live));
   assign wake_req = any_reset | priority_pin_request | gen_wake;
   // masked priority pin wake resumes without entering service
   assign wake_no_service = priority_pin_request & cpu_x_mask & ~any_reset & ~gen_wake;

   wire pending = any_reset | trap_req | software_interrupt | prio_taken | ext_taken | gen_found;

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // writable at any time
   assign vector_base_page_d = base_write ?
      wb_dat_i[exception_vector_pkg::BASE_FIELD_LSB +: exception_vector_pkg::BASE_FIELD_W] :
      vector_base_page_q;

   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[exception_vector_pkg::STAT_VECTOR_LSB +: 16] = sel_vector;
      status_word[exception_vector_pkg::STAT_WAKE_BIT] = wake_req;
      status_word[exception_vector_pkg::STAT_DEBUG_BIT] = debug_active;
      status_word[exception_vector_pkg::STAT_PENDING_BIT] = pending;
      status_word[exception_vector_pkg::STAT_RESET_BIT] = any_reset;
   end

   // unmapped addresses read zero and ignore writes
   wire [31:0] base_word = {24'h00_0000, vector_base_page_q};
   assign wb_dat_d = hit_base ? base_word : (hit_status ? status_word : 32'h0000_0000);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         vector_base_page_q <= exception_vector_pkg::BASE_PAGE_RESET;
      end else begin
         vector_base_page_q <= vector_base_page_d;
      end
   end

   // single wait state, ack drops the cycle after it was given
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h0000_0000;
      end else begin
         wb_ack_q <= bus_req;
         wb_dat_q <= bus_req ? wb_dat_d : wb_dat_q;
      end
   end

   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   a_base_low_zero: assert property (
      vector_req & ~any_reset |-> vector_out[7:0] >= exception_vector_pkg::OFF_SPURIOUS
         && vector_out[0] == 1'b0)
      else $error("vector low byte out of table");

   a_spurious_empty: assert property (
      vector_req & ~pending |-> vector_out == {page, exception_vector_pkg::OFF_SPURIOUS})
      else $error("spurious vector not returned");

   a_general_range: assert property (
      vector_req & gen_found & ~any_reset & ~trap_req & ~software_interrupt & ~prio_taken
         & ~ext_taken |-> vector_out[7:0] inside {[8'h82:8'hF0]})
      else $error("general vector outside range");

   a_ext_over_general: assert property (
      vector_req & ext_taken & ~prio_taken & ~any_reset |-> vector_out[7:0] == 8'hF2)
      else $error("external pin vector wrong");

   a_prio_vector: assert property (
      vector_req & prio_taken & ~trap_req & ~software_interrupt & ~any_reset
         |-> vector_out[7:0] == 8'hF4)
      else $error("priority pin vector wrong");

   a_software_vector: assert property (
      vector_req & software_interrupt & ~trap_req & ~any_reset |-> vector_out[7:0] == 8'hF6)
      else $error("software vector wrong");

   a_trap_vector: assert property (
      vector_req & trap_req & ~any_reset |-> vector_out == {page, 8'hF8})
      else $error("trap vector wrong");

   a_reset_fixed: assert property (
      vector_req & rst_pin_req |-> vector_out == 16'hFFFE)
      else $error("pin reset vector wrong");

   a_reset_order: assert property (
      vector_req & ~rst_pin_req & rst_clock_req |-> vector_out == 16'hFFFC)
      else $error("clock reset vector wrong");

   a_page_after_reset: assert property (
      $fell(sys_rst) |-> vector_base_page_q == 8'hFF)
      else $error("base page not all ones after reset");

   a_debug_page: assert property (
      vector_req & debug_active & ~any_reset |-> vector_out[15:8] == 8'hFF)
      else $error("debug page not forced");

   a_page_write: assert property (
      base_write |=> vector_base_page_q == $past(wb_dat_i[7:0]) ##1 wb_ack_o == 1'b0)
      else $error("base page write lost");

   a_mask_blocks: assert property (
      vector_req & cpu_i_mask & ~any_reset & ~trap_req & ~software_interrupt & ~prio_taken
         |-> vector_out[7:0] == 8'h80)
      else $error("masked general request taken");

   a_hold_stable: assert property (
      vector_req & $stable(sel_vector) ##1 vector_req & $stable(sel_vector)
         |-> $stable(vector_out))
      else $error("vector moved while strobe held");

   a_wake_masked: assert property (
      cpu_i_mask & ~any_reset & ~priority_pin_request |-> ~wake_req)
      else $error("masked general request woke cpu");

   a_prio_wake: assert property (
      priority_pin_request |-> wake_req)
      else $error("priority pin did not wake");

   a_ack_one: assert property (
      wb_ack_o |=> ~wb_ack_o)
      else $error("ack held over two cycles");

   a_ack_latency: assert property (
      bus_req |=> wb_ack_o)
      else $error("bus access not acknowledged");

   a_ext_enable: assert property (
      vector_req & ext_taken & gen_found & ~any_reset |-> vector_out[7:0] == 8'hF2)
      else $error("external pin lost to general source");

   a_gen_top: assert property (
      vector_req & ~any_reset & ~high_pending & ~ext_taken & ~cpu_i_mask & gen_live[GEN_N-1]
         |-> vector_out[7:0] == 8'(exception_vector_pkg::OFF_GEN_FIRST + 2 * (GEN_N - 1)))
      else $error("top general source not selected");

   a_prio_preempt: assert property (
      vector_req & priority_pin_request & ~cpu_x_mask & ~trap_req & ~software_interrupt
         & ~any_reset |-> vector_out[7:0] == 8'hF4)
      else $error("priority pin did not preempt");

   a_raw_pin_blocks: assert property (
      vector_req & priority_pin_request & cpu_x_mask & ~trap_req & ~software_interrupt
         & ~any_reset |-> vector_out[7:0] == 8'h80)
      else $error("general taken beside priority pin");

   a_live_trap: assert property (
      vector_req & $past(vector_req) & trap_req & ~$past(trap_req) & ~any_reset
         |-> vector_out[7:0] == 8'hF8)
      else $error("late trap not returned");

   a_strobe_valid: assert property (
      vector_req |-> vector_valid)
      else $error("vector not valid under strobe");

   a_idle_zero: assert property (
      ~vector_req |-> vector_out == 16'h0000 && ~vector_valid)
      else $error("vector shown without strobe");

   a_wake_general: assert property (
      ~cpu_i_mask & (|gen_live) |-> wake_req)
      else $error("enabled general request did not wake");

   a_reset_watchdog: assert property (
      vector_req & rst_watchdog_req & ~rst_pin_req & ~rst_clock_req
         |-> vector_out == 16'hFFFA)
      else $error("watchdog reset vector moved");

   c_general_vector: cover property (vector_req & gen_found & ~ext_taken & ~prio_taken);
   c_spurious: cover property (vector_req & ~pending);
   c_preempt: cover property (vector_req & prio_taken & |gen_live);
   c_page_write: cover property (base_write ##2 vector_req);
   c_live_trap: cover property (vector_req & $past(vector_req) & $rose(trap_req));

endmodule

// ==== tb/cpu_vector_model.sv ====
// cpu side of the vector handshake: raises the strobe on command and
// captures the vector shown while the strobe stands
// assumes want is driven by the bench just after rising edges
`timescale 1ns/1ps

module cpu_vector_model (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic want,
   input wire logic [15:0] vector_out,
   input wire logic vector_valid,
   output logic vector_req,
   output logic [15:0] vector_seen
);
   // ----------------------------------------------------------------
   // strobe and capture
   // ----------------------------------------------------------------
   // strobe held, vector taken
   // a missing valid leaves a marker, not a stale vector
   always_ff @(posedge sys_clk) begin
      vector_req <= sys_rst ? 1'b0 : want;
      vector_seen <= (vector_req && vector_valid) ? vector_out : 16'h0BAD;
   end
endmodule

// ==== tb/exception_vector_prioritizer_tb.sv ====
// bench for the exception vector prioritizer: register bus, priority,
// masking, debug page, live re-evaluation and wake outputs
// assumes the design and cpu_vector_model are compiled before it
`timescale 1ns/1ps

module exception_vector_prioritizer_tb;
   localparam int GN = 56;
   logic sys_clk = 1'b0, sys_rst = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic rst_pin_req = 0, rst_clock_req = 0, rst_watchdog_req = 0, trap_req = 0;
   logic software_interrupt = 0, priority_pin_request = 0, ext_pin_req = 0;
   logic ext_pin_enable = 1, cpu_i_mask = 0, cpu_x_mask = 0, debug_active = 0, want = 0;
   logic [GN-1:0] gen_req = '0, gen_enable = '1;
   logic vector_req, vector_valid, wake_req, wake_no_service;
   logic [15:0] vector_out, vector_seen, v;
   logic [15:0] exp_tab [0:8] = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'h12F8, 16'h12F6,
      16'h12F4, 16'h12F2, 16'h12F0, 16'h1280};
   int mismatches = 0, checks = 0;

   always #4 sys_clk = ~sys_clk;

   exception_vector_prioritizer #(.GEN_N(GN)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .rst_pin_req(rst_pin_req), .rst_clock_req(rst_clock_req),
      .rst_watchdog_req(rst_watchdog_req), .trap_req(trap_req),
      .software_interrupt(software_interrupt), .priority_pin_request(priority_pin_request),
      .ext_pin_req(ext_pin_req), .ext_pin_enable(ext_pin_enable), .gen_req(gen_req),
      .gen_enable(gen_enable), .cpu_i_mask(cpu_i_mask), .cpu_x_mask(cpu_x_mask),
      .debug_active(debug_active), .vector_req(vector_req), .vector_out(vector_out),
      .vector_valid(vector_valid), .wake_req(wake_req), .wake_no_service(wake_no_service));

   cpu_vector_model u_cpu (.sys_clk(sys_clk), .sys_rst(sys_rst), .want(want),
      .vector_out(vector_out), .vector_valid(vector_valid), .vector_req(vector_req),
      .vector_seen(vector_seen));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task conclude;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task wb(input logic we, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
      wb_adr_i <= a; wb_sel_i <= s; wb_dat_i <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         mismatches++;
         conclude();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
      @(posedge sys_clk);
   endtask

   task fetch;
      want <= 1'b1;
      repeat (2) @(posedge sys_clk);
      want <= 1'b0;
      @(posedge sys_clk);
      v = vector_seen;
   endtask

   task drive(input logic [7:0] s);
      rst_pin_req <= s[7]; rst_clock_req <= s[6]; rst_watchdog_req <= s[5];
      trap_req <= s[4]; software_interrupt <= s[3]; priority_pin_request <= s[2];
      ext_pin_req <= s[1]; gen_req <= {GN{s[0]}};
   endtask

   task wake(input logic w, input logic ns);
      @(negedge sys_clk);
      check(wake_req, w);
      check(wake_no_service, ns);
      @(posedge sys_clk);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset_page;
      wb(0, 4'h0, 4'hF, 32'h0); check(rd, 32'h0000_00FF);
      fetch(); check(v, 16'hFF80);
      wb(1, 4'hC, 4'hF, 32'h77); wb(0, 4'hC, 4'hF, 32'h0); check(rd, 32'h0);
   endtask

   task t_page_rw;
      wb(1, 4'h0, 4'hF, 32'h12); wb(1, 4'h0, 4'h0, 32'h34);
      wb(0, 4'h0, 4'hF, 32'h0); check(rd, 32'h0000_0012);
      fetch(); check(v, 16'h1280);
   endtask

   task t_priority;
      for (int k = 0; k < 9; k++) begin
         drive(8'hFF >> k);
         fetch(); check(v, exp_tab[k]);
      end
   endtask

   task t_general;
      gen_req <= {{(GN-1){1'b0}}, 1'b1};
      fetch(); check(v, 16'h1282);
      gen_enable <= {{(GN-1){1'b1}}, 1'b0};
      fetch(); check(v, 16'h1280);
      gen_enable <= '1; cpu_i_mask <= 1'b1;
      fetch(); check(v, 16'h1280);
      wake(1'b0, 1'b0);
      cpu_i_mask <= 1'b0; software_interrupt <= 1'b1;
      fetch(); check(v, 16'h12F6);
      wb(0, 4'h4, 4'hF, 32'h0); check(rd, 32'h0005_12F6);
      wake(1'b1, 1'b0);
      software_interrupt <= 1'b0; ext_pin_req <= 1'b1; ext_pin_enable <= 1'b0;
      fetch(); check(v, 16'h1282);
      ext_pin_enable <= 1'b1;
      fetch(); check(v, 16'h12F2);
      drive(8'h0);
   endtask

   task t_prio_pin;
      drive(8'h05);
      fetch(); check(v, 16'h12F4);
      cpu_x_mask <= 1'b1; cpu_i_mask <= 1'b1;
      fetch(); check(v, 16'h1280);
      wake(1'b1, 1'b1);
      cpu_x_mask <= 1'b0; cpu_i_mask <= 1'b0; drive(8'h0);
   endtask

   task t_debug;
      debug_active <= 1'b1; software_interrupt <= 1'b1;
      fetch(); check(v, 16'hFFF6);
      debug_active <= 1'b0;
      fetch(); check(v, 16'h12F6);
      software_interrupt <= 1'b0;
   endtask

   task t_live;
      gen_req <= '1; want <= 1'b1;
      repeat (2) @(posedge sys_clk);
      check(vector_out, 16'h12F0);
      check(vector_valid, 1'b1);
      trap_req <= 1'b1;
      @(negedge sys_clk); check(vector_out, 16'h12F8);
      @(posedge sys_clk);
      want <= 1'b0; drive(8'h0);
      repeat (2) @(posedge sys_clk);
   endtask

   task t_mid_reset;
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      wb(0, 4'h0, 4'hF, 32'h0); check(rd, 32'h0000_00FF);
      rst_clock_req <= 1'b1;
      fetch(); check(v, 16'hFFFC);
   endtask

   initial begin
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_reset_page(); t_page_rw(); t_priority(); t_general();
      t_prio_pin(); t_debug(); t_live(); t_mid_reset();
      conclude();
   end
endmodule
